//--- rtl/clk_monitor_pkg.sv
// Purpose: Shared constants and types of the clock failure monitor
// Assumes: 8-bit register port, 125 MHz core clock
// Notes:   Source, mode and register codes are local encodings
package clk_monitor_pkg;

   // Register port geometry
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;

   // Register offsets
   localparam logic [3:0] ADDR_OSC_CTRL1 = 4'h0;
   localparam logic [3:0] ADDR_IRQ_REQ1  = 4'h1;
   localparam logic [3:0] ADDR_IRQ_EN1   = 4'h2;
   localparam logic [3:0] ADDR_STATUS    = 4'h3;

   // Field positions
   localparam int SRC_LSB      = 4;
   localparam int SRC_MSB      = 6;
   localparam int DIV_LSB      = 0;
   localparam int DIV_MSB      = 3;
   localparam int OSF_BIT      = 7;
   localparam int STAT_FS_BIT  = 0;
   localparam int STAT_OST_BIT = 1;
   localparam int STAT_MON_BIT = 2;
   localparam int STAT_SRC_LSB = 4;
   localparam int STAT_SRC_MSB = 6;

   // Clock source codes
   localparam logic [2:0] SRC_EXT_PLL = 3'h1;
   localparam logic [2:0] SRC_LFINT   = 3'h5;
   localparam logic [2:0] SRC_HFINT   = 3'h6;
   localparam logic [2:0] SRC_EXT     = 3'h7;

   // Oscillator configuration modes
   localparam logic [2:0] MODE_LP  = 3'h0;
   localparam logic [2:0] MODE_XT  = 3'h1;
   localparam logic [2:0] MODE_HS  = 3'h2;
   localparam logic [2:0] MODE_ECL = 3'h3;
   localparam logic [2:0] MODE_ECM = 3'h4;
   localparam logic [2:0] MODE_ECH = 3'h5;

   // Reset values and fail-safe clock setting
   localparam logic [7:0] RST_CTRL1   = 8'h70;
   localparam logic [3:0] FS_DIV_1MHZ = 4'h0;

   // Sample clock divide and start-up count
   localparam int SAMPLE_DIV = 64;
   localparam int OST_CYCLES = 1024;

   typedef enum {ST_BOOT, ST_OST, ST_RUN, ST_FAIL, ST_INT, ST_SLEEP} fsm_state_t;

   // True for either external source code
   function automatic logic is_ext_src(input logic [2:0] src);
      return (src == SRC_EXT) || (src == SRC_EXT_PLL);
   endfunction : is_ext_src

   // True for the clock-input modes that skip the start-up timer
   function automatic logic is_ec_mode(input logic [2:0] mode);
      return (mode == MODE_ECL) || (mode == MODE_ECM) || (mode == MODE_ECH);
   endfunction : is_ec_mode

endpackage : clk_monitor_pkg

//--- rtl/sample_clock_divider.sv
// Purpose: Divides the low-frequency oscillator into sample clock edges
// Assumes: src_rise is a one-cycle pulse per oscillator rising edge
// Notes:   Emits one pulse per sample rising and falling edge
`timescale 1ns/100ps
module sample_clock_divider #(
   parameter int DIV = 64
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Oscillator edge in
   input  wire logic src_rise,
   // Sample clock edges out
   output logic      samp_rise_r,
   output logic      samp_fall_r
);

   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);

   logic [CW-1:0] cnt_r;

   // Oscillator edge counter, wraps every DIV edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (src_rise) begin
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      end
   end

   // Sample edge pulses at wrap and mid-count
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_rise_r <= 1'b0;
         samp_fall_r <= 1'b0;
      end else begin
         samp_rise_r <= src_rise && (cnt_r == LAST);
         samp_fall_r <= src_rise && (cnt_r == HALF);
      end
   end

endmodule : sample_clock_divider

//--- rtl/clock_failure_monitor.sv
// Purpose: Watches the external oscillator and falls back to an internal clock
// Assumes: Pins sampled at 125 MHz; external clock well below 62 MHz
// Notes:   Clock selection is reported as codes; the glitch-free mux is outside
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps

// Overview of operation
// - Monitoring and switchover happen only while the monitor-enable config bit is set.
// - Monitoring covers all crystal and external clock-input modes alike.
// - Sample clock is the low-frequency internal oscillator divided by 64.
// - External falling edge sets the detector latch; sample rising edge clears it.
// - A full sample half-cycle with no external low edge means failure.
// - On failure the system clock moves to the internal oscillator at 1 MHz.
// - On failure the oscillator-fail flag is set.
// - Interrupt request when the fail flag and its enable are both set.
// - Stay on the internal clock until firmware writes new source and divider.
// - Fail-safe clears on reset, sleep, or a source and divider write.
// - Switching to the external oscillator, with or without PLL, restarts the timer.
// - While the timer counts, run from the currently selected internal oscillator.
// - Timer expiry and a successful switch to external clear fail-safe; here the source write itself already clears it.
// - A clock still failing after switch-back sets the flag again; in crystal modes it keeps the timer running and sets no flag.
// - Failure detection starts only after the start-up timer expires.
// - Start-up timer runs after every wake-up and every reset; here a wake-up with an internal source selected skips it.
// - Clock-input modes skip the timer; monitoring starts immediately.
// - Code keeps running on an internal clock during the timer period.
module clock_failure_monitor #(
   parameter int OST_CYCLES = clk_monitor_pkg::OST_CYCLES
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Oscillator pins
   input  wire logic       ext_clk_pin,
   input  wire logic       low_freq_internal_osc,
   // Configuration and power events
   input  wire logic       monitor_enable_config,
   input  wire logic [2:0] osc_mode,
   input  wire logic       sleep_exec,
   input  wire logic       wake_done,
   // Register port
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data_r,
   // Clock selection and status
   output logic      [2:0] sys_clk_src_r,
   output logic      [3:0] sys_clk_div_r,
   output logic            fail_safe_r,
   output logic            ost_running_r,
   output logic            irq_req_r
);

   localparam int OW = $clog2(OST_CYCLES + 1);
   localparam logic [OW-1:0] OST_LAST = OW'(OST_CYCLES - 1);

   clk_monitor_pkg::fsm_state_t state_r;
   clk_monitor_pkg::fsm_state_t state_nxt;

   logic          ext_s1_r;
   logic          ext_s2_r;
   logic          ext_s3_r;
   logic          lf_s1_r;
   logic          lf_s2_r;
   logic          lf_s3_r;
   logic          ext_fall;
   logic          lf_rise;
   logic          samp_rise;
   logic          samp_fall;
   logic          det_r;
   logic          mon_on;
   logic          fail_evt;
   logic [OW-1:0] ost_cnt_r;
   logic          ost_done;
   logic [7:0]    osc_control_1_r;
   logic          osc_fail_flag_r;
   logic          osc_fail_irq_enable_r;
   logic          ctrl_wr;
   logic          flag_clr;
   logic [2:0]    ctrl_src;
   logic [3:0]    ctrl_div;

   // Pin synchronisers plus one edge-detect stage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
         lf_s1_r  <= 1'b0;
         lf_s2_r  <= 1'b0;
         lf_s3_r  <= 1'b0;
      end else begin
         ext_s1_r <= ext_clk_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         lf_s1_r  <= low_freq_internal_osc;
         lf_s2_r  <= lf_s1_r;
         lf_s3_r  <= lf_s2_r;
      end
   end

   // Edge pulses of the synchronised pins
   assign ext_fall = ext_s3_r && !ext_s2_r;
   assign lf_rise  = !lf_s3_r && lf_s2_r;

   // Sample clock from the low-frequency oscillator
   sample_clock_divider #(
      .DIV (clk_monitor_pkg::SAMPLE_DIV)
   ) u_sample_div (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .src_rise    (lf_rise),
      .samp_rise_r (samp_rise),
      .samp_fall_r (samp_fall)
   );

   // Register access decode
   assign ctrl_wr  = wr_en && (addr == clk_monitor_pkg::ADDR_OSC_CTRL1);
   assign flag_clr = wr_en && (addr == clk_monitor_pkg::ADDR_IRQ_REQ1)
                     && !wr_data[clk_monitor_pkg::OSF_BIT];
   assign ctrl_src = osc_control_1_r[clk_monitor_pkg::SRC_MSB:clk_monitor_pkg::SRC_LSB];
   assign ctrl_div = osc_control_1_r[clk_monitor_pkg::DIV_MSB:clk_monitor_pkg::DIV_LSB];

   // Monitoring is live only in external run with the config bit set
   assign mon_on   = monitor_enable_config && (state_r == clk_monitor_pkg::ST_RUN);
   // Falling sample edge with the latch still clear: a dead half-cycle
   assign fail_evt = mon_on && samp_fall && !det_r && !ext_fall;
   assign ost_done = (state_r == clk_monitor_pkg::ST_OST) && ext_fall
                     && (ost_cnt_r == OST_LAST);

   // Detector latch, armed while idle so the first half-cycle is clean
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         det_r <= 1'b1;
      end else if (!mon_on || ext_fall) begin
         det_r <= 1'b1;
      end else if (samp_rise) begin
         det_r <= 1'b0;
      end
   end

   // Start-up timer counts external falling edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ost_cnt_r <= '0;
      end else if (ctrl_wr || (state_r != clk_monitor_pkg::ST_OST)) begin
         ost_cnt_r <= '0;
      end else if (ext_fall) begin
         ost_cnt_r <= ost_cnt_r + 1'b1;
      end
   end

   // Entry state after a source choice, reset or wake-up
   function automatic clk_monitor_pkg::fsm_state_t go_state(input logic [2:0] src);
      if (!clk_monitor_pkg::is_ext_src(src)) begin
         return clk_monitor_pkg::ST_INT;
      end else if (clk_monitor_pkg::is_ec_mode(osc_mode)) begin
         return clk_monitor_pkg::ST_RUN;
      end else begin
         return clk_monitor_pkg::ST_OST;
      end
   endfunction : go_state

   // Next state: sleep first, then source writes, then own progress
   always_comb begin
      state_nxt = state_r;
      if (sleep_exec) begin
         state_nxt = clk_monitor_pkg::ST_SLEEP;
      end else if (ctrl_wr) begin
         state_nxt = go_state(wr_data[clk_monitor_pkg::SRC_MSB:clk_monitor_pkg::SRC_LSB]);
      end else begin
         case (state_r)
            clk_monitor_pkg::ST_BOOT: begin
               state_nxt = go_state(ctrl_src);
            end
            clk_monitor_pkg::ST_SLEEP: begin
               if (wake_done) begin
                  state_nxt = go_state(ctrl_src);
               end
            end
            clk_monitor_pkg::ST_OST: begin
               if (ost_done) begin
                  state_nxt = clk_monitor_pkg::ST_RUN;
               end
            end
            clk_monitor_pkg::ST_RUN: begin
               if (fail_evt) begin
                  state_nxt = clk_monitor_pkg::ST_FAIL;
               end
            end
            clk_monitor_pkg::ST_FAIL: begin
               state_nxt = clk_monitor_pkg::ST_FAIL;
            end
            clk_monitor_pkg::ST_INT: begin
               state_nxt = clk_monitor_pkg::ST_INT;
            end
            default: begin
               state_nxt = clk_monitor_pkg::ST_BOOT;
            end
         endcase
      end
   end

   // State register; reset lands in boot, which picks the timer path except in clock-input modes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= clk_monitor_pkg::ST_BOOT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Clock source and divider follow the state one cycle later
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_clk_src_r <= clk_monitor_pkg::SRC_HFINT;
         sys_clk_div_r <= clk_monitor_pkg::FS_DIV_1MHZ;
      end else begin
         case (state_r)
            clk_monitor_pkg::ST_FAIL: begin
               sys_clk_src_r <= clk_monitor_pkg::SRC_HFINT;
               sys_clk_div_r <= clk_monitor_pkg::FS_DIV_1MHZ;
            end
            clk_monitor_pkg::ST_RUN, clk_monitor_pkg::ST_INT: begin
               sys_clk_src_r <= ctrl_src;
               sys_clk_div_r <= ctrl_div;
            end
            clk_monitor_pkg::ST_OST, clk_monitor_pkg::ST_BOOT: begin
               // Keep the internal clock so code runs during start-up
               if (clk_monitor_pkg::is_ext_src(sys_clk_src_r)) begin
                  sys_clk_src_r <= clk_monitor_pkg::SRC_HFINT;
               end else begin
                  sys_clk_src_r <= sys_clk_src_r;
               end
            end
            default: begin
               sys_clk_src_r <= sys_clk_src_r;
            end
         endcase
      end
   end

   // Status outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fail_safe_r   <= 1'b0;
         ost_running_r <= 1'b0;
      end else begin
         fail_safe_r   <= (state_r == clk_monitor_pkg::ST_FAIL);
         ost_running_r <= (state_r == clk_monitor_pkg::ST_OST);
      end
   end

   // Oscillator control register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_control_1_r <= clk_monitor_pkg::RST_CTRL1;
      end else if (ctrl_wr) begin
         osc_control_1_r <= wr_data;
      end
   end

   // Fail flag: hardware set beats a software clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_fail_flag_r <= 1'b0;
      end else if (fail_evt) begin
         osc_fail_flag_r <= 1'b1;
      end else if (flag_clr) begin
         osc_fail_flag_r <= 1'b0;
      end
   end

   // Interrupt enable
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_fail_irq_enable_r <= 1'b0;
      end else if (wr_en && (addr == clk_monitor_pkg::ADDR_IRQ_EN1)) begin
         osc_fail_irq_enable_r <= wr_data[clk_monitor_pkg::OSF_BIT];
      end
   end

   // Interrupt request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_req_r <= 1'b0;
      end else begin
         irq_req_r <= osc_fail_flag_r && osc_fail_irq_enable_r;
      end
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= '0;
         if (rd_en) begin
            case (addr)
               clk_monitor_pkg::ADDR_OSC_CTRL1: begin
                  rd_data_r <= osc_control_1_r;
               end
               clk_monitor_pkg::ADDR_IRQ_REQ1: begin
                  rd_data_r[clk_monitor_pkg::OSF_BIT] <= osc_fail_flag_r;
               end
               clk_monitor_pkg::ADDR_IRQ_EN1: begin
                  rd_data_r[clk_monitor_pkg::OSF_BIT] <= osc_fail_irq_enable_r;
               end
               clk_monitor_pkg::ADDR_STATUS: begin
                  rd_data_r[clk_monitor_pkg::STAT_FS_BIT]  <= fail_safe_r;
                  rd_data_r[clk_monitor_pkg::STAT_OST_BIT] <= ost_running_r;
                  rd_data_r[clk_monitor_pkg::STAT_MON_BIT] <= mon_on;
                  rd_data_r[clk_monitor_pkg::STAT_SRC_MSB:clk_monitor_pkg::STAT_SRC_LSB]
                     <= sys_clk_src_r;
               end
               default: begin
                  rd_data_r <= '0;
               end
            endcase
         end
      end
   end

   // Checks on the monitor behaviour
   default clocking cb_core @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_mon_disabled;
      !monitor_enable_config |-> !fail_evt && !mon_on;
   endproperty
   a_mon_disabled: assert property (p_mon_disabled)
      else $error("monitor acted with config bit clear");

   property p_fail_enters;
      fail_evt && !sleep_exec && !ctrl_wr |=> state_r == clk_monitor_pkg::ST_FAIL;
   endproperty
   a_fail_enters: assert property (p_fail_enters)
      else $error("dead half-cycle did not enter fail-safe");

   property p_fail_clock;
      $rose(state_r == clk_monitor_pkg::ST_FAIL) ##1 (state_r == clk_monitor_pkg::ST_FAIL)
         |-> sys_clk_src_r == clk_monitor_pkg::SRC_HFINT
             && sys_clk_div_r == clk_monitor_pkg::FS_DIV_1MHZ && fail_safe_r;
   endproperty
   a_fail_clock: assert property (p_fail_clock)
      else $error("fail-safe did not select internal 1 MHz clock");

   property p_flag_set;
      fail_evt |=> osc_fail_flag_r ##1 irq_req_r == osc_fail_irq_enable_r;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("failure did not set the flag");

   property p_irq;
      irq_req_r == $past(osc_fail_flag_r && osc_fail_irq_enable_r);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt request does not follow flag and enable");

   property p_fail_holds;
      state_r == clk_monitor_pkg::ST_FAIL && !ctrl_wr && !sleep_exec
         |=> state_r == clk_monitor_pkg::ST_FAIL;
   endproperty
   a_fail_holds: assert property (p_fail_holds)
      else $error("fail-safe left without a source write");

   property p_ost_restart;
      ctrl_wr && !sleep_exec
         && clk_monitor_pkg::is_ext_src(wr_data[clk_monitor_pkg::SRC_MSB:clk_monitor_pkg::SRC_LSB])
         |=> state_r == (clk_monitor_pkg::is_ec_mode(osc_mode) ?
                         clk_monitor_pkg::ST_RUN : clk_monitor_pkg::ST_OST) && ost_cnt_r == '0;
   endproperty
   a_ost_restart: assert property (p_ost_restart)
      else $error("external switch did not restart start-up timer");

   property p_no_detect_in_ost;
      state_r == clk_monitor_pkg::ST_OST |-> !mon_on && !fail_evt ##1 !fail_safe_r;
   endproperty
   a_no_detect_in_ost: assert property (p_no_detect_in_ost)
      else $error("detection active while start-up timer runs");

   property p_ost_internal;
      state_r == clk_monitor_pkg::ST_OST |=> !clk_monitor_pkg::is_ext_src(sys_clk_src_r);
   endproperty
   a_ost_internal: assert property (p_ost_internal)
      else $error("external clock used before timer expiry");

   property p_flag_sticky;
      osc_fail_flag_r && !flag_clr |=> osc_fail_flag_r;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("fail flag dropped without a software clear");

   property p_ost_done;
      ost_done && !sleep_exec && !ctrl_wr |=> state_r == clk_monitor_pkg::ST_RUN
         ##1 (sys_clk_src_r == ctrl_src && !fail_safe_r);
   endproperty
   a_ost_done: assert property (p_ost_done)
      else $error("timer expiry did not switch to external clock");

   c_failure:   cover property (fail_evt);
   c_ost_done:  cover property (ost_done);
   c_refail:    cover property (fail_evt ##[1:1000] ctrl_wr ##[1:1000] fail_evt);
   c_set_clear: cover property (fail_evt && flag_clr);

endmodule : clock_failure_monitor

//--- testbench/ext_osc_model.sv
// Purpose: Behavioural external oscillator on the monitored clock pin
// Assumes: run and slow are levels set by the bench
// Notes:   A stopped oscillator freezes at its last level, like a dead crystal
`timescale 1ns/100ps
module ext_osc_model #(
   parameter int HALF_NS = 40
) (
   // Controls
   input  wire logic run,
   input  wire logic slow,
   // Oscillator output
   output logic      osc_out
);
   logic lvl = 1'b0;

   // Toggle while running; slow stretches the period eightfold
   always begin
      #(slow ? HALF_NS * 8 : HALF_NS);
      if (run) lvl = ~lvl;
   end
   assign osc_out = lvl;
endmodule : ext_osc_model

//--- testbench/fail_safe_clock_monitor_tb_top.sv
// Purpose: Self-checking bench for the clock failure monitor
// Assumes: Start-up count of 8, low-frequency oscillator at 4 core cycles
// Notes:   Every oscillator mode is run into a failure in turn
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); n_errors++; end end
module fail_safe_clock_monitor_tb_top;
   // Clocks, pins and controls
   logic       core_clk   = 1'b0;
   logic       rst_n      = 1'b0;
   logic       lf_osc     = 1'b0;
   logic       ext_clk;
   logic       run        = 1'b1;
   logic       slow       = 1'b0;
   logic       mon_en     = 1'b1;
   logic [2:0] mode       = 3'h0;
   logic       sleep_exec = 1'b0;
   logic       wake_done  = 1'b0;
   logic [3:0] addr       = 4'h0;
   logic [7:0] wr_data    = 8'h00;
   logic       wr_en      = 1'b0;
   logic       rd_en      = 1'b0;
   logic [7:0] rd_data_r;
   logic [7:0] rdv;
   logic [2:0] src;
   logic [3:0] div;
   logic       fs;
   logic       osc_startup_timer;
   logic       irq;
   int         n_errors   = 0;
   int         tests_run  = 0;
   int         i;

   // Core clock and low-frequency oscillator
   always #4 core_clk = ~core_clk;
   always #16 lf_osc = ~lf_osc;

   ext_osc_model u_osc (.run(run), .slow(slow), .osc_out(ext_clk));

   clock_failure_monitor #(.OST_CYCLES(8)) u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .ext_clk_pin(ext_clk),
      .low_freq_internal_osc(lf_osc), .monitor_enable_config(mon_en),
      .osc_mode(mode), .sleep_exec(sleep_exec), .wake_done(wake_done),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data_r(rd_data_r), .sys_clk_src_r(src), .sys_clk_div_r(div),
      .fail_safe_r(fs), .ost_running_r(osc_startup_timer), .irq_req_r(irq));

   // Settle past the edge before sampling
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge core_clk);
      wr_en   <= 1'b0;
   endtask : wr

   // Read; data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 rdv = rd_data_r;
   endtask : rd

   // Reset held four cycles under a given mode
   task automatic do_reset(input logic [2:0] m);
      @(posedge core_clk);
      mode  <= m;
      rst_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
   endtask : do_reset

   // Bounded waits on the selected source and the fail-safe level
   task automatic wait_ext();
      for (i = 0; i < 2000 && src !== clk_monitor_pkg::SRC_EXT; i++) tick(1);
   endtask : wait_ext
   task automatic wait_fs();
      for (i = 0; i < 500 && fs !== 1'b1; i++) tick(1);
   endtask : wait_fs

   // Counts and verdict, then stop
   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // Watchdog against a hang
   initial begin
      #200000;
      n_errors++;
      finish_test();
   end

   // Main sequence
   initial begin
      do_reset(clk_monitor_pkg::MODE_LP);
      rd(clk_monitor_pkg::ADDR_OSC_CTRL1);
      `CHK("ctrl", clk_monitor_pkg::RST_CTRL1, rdv)
      rd(4'hf);
      `CHK("unmapped", 8'h00, rdv)
      $display("test reset_values done");
      for (int m = 5; m >= 0; m--) begin
         run <= 1'b1;
         do_reset(3'(m));
         tick(3);
         `CHK("ost", 1'(m < 3), osc_startup_timer)
         if (m < 3) `CHK("src", clk_monitor_pkg::SRC_HFINT, src)
         wait_ext();
         `CHK("src", clk_monitor_pkg::SRC_EXT, src)
         wr(clk_monitor_pkg::ADDR_IRQ_EN1, 8'h80);
         run <= 1'b0;
         tick(100);
         `CHK("early", 1'b0, fs)
         wait_fs();
         `CHK("fs", 1'b1, fs)
         `CHK("src", clk_monitor_pkg::SRC_HFINT, src)
         `CHK("div", clk_monitor_pkg::FS_DIV_1MHZ, div)
         rd(clk_monitor_pkg::ADDR_IRQ_REQ1);
         `CHK("flag", 8'h80, rdv)
         `CHK("irq", 1'b1, irq)
         $display("test mode %0d done", m);
      end
      // Flag ignores a write of one, mask drops the request
      wr(clk_monitor_pkg::ADDR_IRQ_REQ1, 8'h80);
      rd(clk_monitor_pkg::ADDR_IRQ_REQ1);
      `CHK("flag", 8'h80, rdv)
      wr(clk_monitor_pkg::ADDR_IRQ_EN1, 8'h00);
      tick(2);
      `CHK("irq", 1'b0, irq)
      tick(300);
      `CHK("src", clk_monitor_pkg::SRC_HFINT, src)
      wr(clk_monitor_pkg::ADDR_IRQ_REQ1, 8'h00);
      rd(clk_monitor_pkg::ADDR_IRQ_REQ1);
      `CHK("flag", 8'h00, rdv)
      // Switch back to the crystal
      run <= 1'b1;
      wr(clk_monitor_pkg::ADDR_OSC_CTRL1, clk_monitor_pkg::RST_CTRL1);
      tick(2);
      `CHK("fs", 1'b0, fs)
      `CHK("ost", 1'b1, osc_startup_timer)
      `CHK("src", clk_monitor_pkg::SRC_HFINT, src)
      wait_ext();
      `CHK("src", clk_monitor_pkg::SRC_EXT, src)
      run <= 1'b0;
      wait_fs();
      rd(clk_monitor_pkg::ADDR_IRQ_REQ1);
      `CHK("flag", 8'h80, rdv)
      $display("test switch_back done");
      // Sleep clears fail-safe, wake restarts the timer
      @(posedge core_clk);
      sleep_exec <= 1'b1;
      @(posedge core_clk);
      sleep_exec <= 1'b0;
      tick(2);
      `CHK("fs", 1'b0, fs)
      run       <= 1'b1;
      wake_done <= 1'b1;
      @(posedge core_clk);
      wake_done <= 1'b0;
      tick(3);
      `CHK("ost", 1'b1, osc_startup_timer)
      wait_ext();
      rd(clk_monitor_pkg::ADDR_STATUS);
      `CHK("status", 8'h74, rdv)
      slow <= 1'b1;
      tick(600);
      `CHK("fs", 1'b0, fs)
      mon_en <= 1'b0;
      run    <= 1'b0;
      tick(600);
      `CHK("fs", 1'b0, fs)
      $display("test sleep_and_disable done");
      finish_test();
   end
endmodule : fail_safe_clock_monitor_tb_top
